// ---- core/fda_config.sv ----
`timescale 1ns/1ps
`include "fda_defines.svh"
// Operation
// - The ramp field picks a duty step of 1, 2, 3, 4, 8, 12, 24 or 48 per slot for drive one.
// - The ramp enable bit turns on stepped ramping for drive one, else duty jumps directly.
// - With the align bit set, speed inputs two, three and four are timed to drive three.
// - With the align bit clear, only inputs three and four follow drive three, two runs free.
// - Drive one floor bit picks 0% or its minimum duty below start temperature less hysteresis.
// - Drive two floor bit picks 0% or its minimum duty below start temperature less hysteresis.
// - Drive three floor bit picks 0% or its minimum duty below start temperature less hysteresis.
// - While the lock is set the register ignores all host writes.
module fda_config
  import fda_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      reset_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic      reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic     [7:0] reg_rdata_r,
  input  wire logic      config_lock,
  input  wire logic      auto_mode,
  input  wire logic      slot_tick,
  input  wire fda_duty_t drive_one_target,
  input  wire fda_duty_t drive_two_target,
  input  wire fda_duty_t drive_three_target,
  input  wire fda_duty_t drive_one_min,
  input  wire fda_duty_t drive_two_min,
  input  wire fda_duty_t drive_three_min,
  input  wire logic [2:0] below_start,
  output fda_duty_t      fan_drive_one_r,
  output fda_duty_t      fan_drive_two_r,
  output fda_duty_t      fan_drive_three_r,
  output logic           speed_input_two_sync_r,
  output logic           speed_input_three_sync_r,
  output logic           speed_input_four_sync_r
);
  logic [7:0] ctrl_r;
  fda_duty_t  ramp_duty;
  fda_duty_t  one_goal;
  fda_duty_t  two_nxt;
  fda_duty_t  three_nxt;

  // Floor choice below start temperature
  function automatic fda_duty_t fda_floor(input logic am, input logic below,
                                           input logic sel, input fda_duty_t mn,
                                           input fda_duty_t tgt);
    if (am && below) fda_floor = sel ? mn : 8'h00;
    else fda_floor = tgt;
  endfunction : fda_floor

  wire logic hit = (reg_addr == `FDA_REG_OFFSET);

  // Register write, blocked by lock
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) ctrl_r <= `FDA_REG_RESET;
    else if (reg_wr && hit && !config_lock) ctrl_r <= reg_wdata;
  end

  // Registered read data
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) reg_rdata_r <= 8'h00;
    else reg_rdata_r <= hit ? ctrl_r : 8'h00;
  end

  // Duty goals with floor selection
  always_comb begin
    one_goal  = fda_floor(auto_mode, below_start[0], ctrl_r[`FDA_FLOOR_ONE_BIT],
                          drive_one_min, drive_one_target);
    two_nxt   = fda_floor(auto_mode, below_start[1], ctrl_r[`FDA_FLOOR_TWO_BIT],
                          drive_two_min, drive_two_target);
    three_nxt = fda_floor(auto_mode, below_start[2], ctrl_r[`FDA_FLOOR_THREE_BIT],
                          drive_three_min, drive_three_target);
  end

  fda_ramp u_ramp (
    .core_clk    (core_clk),
    .reset_n     (reset_n),
    .ramp_enable (ctrl_r[`FDA_RAMP_EN_BIT]),
    .ramp_code   (ctrl_r[`FDA_RAMP_MSB:`FDA_RAMP_LSB]),
    .slot_tick   (slot_tick),
    .target      (one_goal),
    .duty_r      (ramp_duty)
  );

  // Drive outputs
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fan_drive_one_r   <= 8'h00;
      fan_drive_two_r   <= 8'h00;
      fan_drive_three_r <= 8'h00;
    end else begin
      fan_drive_one_r   <= ramp_duty;
      fan_drive_two_r   <= two_nxt;
      fan_drive_three_r <= three_nxt;
    end
  end

  // Speed measurement alignment to drive three
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      speed_input_two_sync_r   <= 1'b0;
      speed_input_three_sync_r <= 1'b0;
      speed_input_four_sync_r  <= 1'b0;
    end else begin
      speed_input_two_sync_r   <= ctrl_r[`FDA_ALIGN_BIT];
      speed_input_three_sync_r <= 1'b1;
      speed_input_four_sync_r  <= 1'b1;
    end
  end

  property p_lock;
    @(posedge core_clk) disable iff (!reset_n)
      config_lock |=> $stable(ctrl_r);
  endproperty
  a_lock: assert property (p_lock) else $error("write passed lock");

  property p_write;
    @(posedge core_clk) disable iff (!reset_n)
      (reg_wr && hit && !config_lock) |=> (ctrl_r == $past(reg_wdata));
  endproperty
  a_write: assert property (p_write) else $error("write lost");

  property p_align;
    @(posedge core_clk) disable iff (!reset_n)
      1'b1 |=> (speed_input_two_sync_r == $past(ctrl_r[`FDA_ALIGN_BIT]));
  endproperty
  a_align: assert property (p_align) else $error("align mismatch");

  property p_fixed_sync;
    @(posedge core_clk) disable iff (!reset_n)
      reset_n |=> (speed_input_three_sync_r && speed_input_four_sync_r);
  endproperty
  a_fixed_sync: assert property (p_fixed_sync) else $error("three/four not synced");

  property p_floor_one;
    @(posedge core_clk) disable iff (!reset_n)
      (auto_mode && below_start[0] && !ctrl_r[`FDA_FLOOR_ONE_BIT]) |-> (one_goal == 8'h00);
  endproperty
  a_floor_one: assert property (p_floor_one) else $error("drive one not off");

  property p_floor_two;
    @(posedge core_clk) disable iff (!reset_n)
      (auto_mode && below_start[1]) |=>
        (fan_drive_two_r == ($past(ctrl_r[`FDA_FLOOR_TWO_BIT]) ? $past(drive_two_min) : 8'h00));
  endproperty
  a_floor_two: assert property (p_floor_two) else $error("drive two floor wrong");

  property p_floor_three;
    @(posedge core_clk) disable iff (!reset_n)
      (auto_mode && below_start[2]) |=>
        (fan_drive_three_r ==
         ($past(ctrl_r[`FDA_FLOOR_THREE_BIT]) ? $past(drive_three_min) : 8'h00));
  endproperty
  a_floor_three: assert property (p_floor_three) else $error("drive three floor wrong");

  // Drive one floor and pass-through ahead of the ramp
  property p_floor_one_min;
    @(posedge core_clk) disable iff (!reset_n)
      (auto_mode && below_start[0] && ctrl_r[`FDA_FLOOR_ONE_BIT])
        |-> (one_goal == drive_one_min);
  endproperty
  a_floor_one_min: assert property (p_floor_one_min) else $error("drive one min lost");

  property p_pass_one;
    @(posedge core_clk) disable iff (!reset_n)
      !(auto_mode && below_start[0]) |-> (one_goal == drive_one_target);
  endproperty
  a_pass_one: assert property (p_pass_one) else $error("drive one target lost");

  // Drives two and three follow their targets outside the floor
  property p_pass_two;
    @(posedge core_clk) disable iff (!reset_n)
      (reset_n && !(auto_mode && below_start[1])) |=>
        (fan_drive_two_r == $past(drive_two_target));
  endproperty
  a_pass_two: assert property (p_pass_two) else $error("drive two target lost");

  property p_pass_three;
    @(posedge core_clk) disable iff (!reset_n)
      (reset_n && !(auto_mode && below_start[2])) |=>
        (fan_drive_three_r == $past(drive_three_target));
  endproperty
  a_pass_three: assert property (p_pass_three) else $error("drive three target lost");

  // Drive one path through the ramp stage
  property p_direct_one;
    @(posedge core_clk) disable iff (!reset_n)
      (reset_n && !ctrl_r[`FDA_RAMP_EN_BIT]) |=> (ramp_duty == $past(one_goal));
  endproperty
  a_direct_one: assert property (p_direct_one) else $error("drive one not direct");

  property p_drive_one_reg;
    @(posedge core_clk) disable iff (!reset_n)
      reset_n |=> (fan_drive_one_r == $past(ramp_duty));
  endproperty
  a_drive_one_reg: assert property (p_drive_one_reg) else $error("drive one lags ramp");

  // Speed input two follows the align bit
  property p_align_set;
    @(posedge core_clk) disable iff (!reset_n)
      (reset_n && ctrl_r[`FDA_ALIGN_BIT]) |=> speed_input_two_sync_r;
  endproperty
  a_align_set: assert property (p_align_set) else $error("input two not aligned");

  property p_align_clear;
    @(posedge core_clk) disable iff (!reset_n)
      (reset_n && !ctrl_r[`FDA_ALIGN_BIT]) |=> !speed_input_two_sync_r;
  endproperty
  a_align_clear: assert property (p_align_clear) else $error("input two not free");

  // Read-back and unmapped accesses
  property p_read_back;
    @(posedge core_clk) disable iff (!reset_n)
      (reset_n && hit) |=> (reg_rdata_r == $past(ctrl_r));
  endproperty
  a_read_back: assert property (p_read_back) else $error("read data wrong");

  property p_read_other;
    @(posedge core_clk) disable iff (!reset_n)
      (reset_n && !hit) |=> (reg_rdata_r == 8'h00);
  endproperty
  a_read_other: assert property (p_read_other) else $error("unmapped read not zero");

  property p_wr_other;
    @(posedge core_clk) disable iff (!reset_n)
      (reg_wr && !hit) |=> $stable(ctrl_r);
  endproperty
  a_wr_other: assert property (p_wr_other) else $error("unmapped write landed");

  c_locked_write: cover property (@(posedge core_clk) reg_wr && hit && config_lock);
  c_open_write: cover property (@(posedge core_clk) reg_wr && hit && !config_lock);
  c_floor_min: cover property (@(posedge core_clk) auto_mode && below_start[1]);
endmodule : fda_config

// ---- core/fda_defines.svh ----
`ifndef FDA_DEFINES_SVH
`define FDA_DEFINES_SVH

// Register placement and reset
`define FDA_REG_OFFSET      8'h62
`define FDA_REG_RESET       8'h00
// Field positions
`define FDA_RAMP_LSB        0
`define FDA_RAMP_MSB        2
`define FDA_RAMP_EN_BIT     3
`define FDA_ALIGN_BIT       4
`define FDA_FLOOR_ONE_BIT   5
`define FDA_FLOOR_TWO_BIT   6
`define FDA_FLOOR_THREE_BIT 7
// Ramp step sizes per code
`define FDA_STEP_0          8'h01
`define FDA_STEP_1          8'h02
`define FDA_STEP_2          8'h03
`define FDA_STEP_3          8'h04
`define FDA_STEP_4          8'h08
`define FDA_STEP_5          8'h0C
`define FDA_STEP_6          8'h18
`define FDA_STEP_7          8'h30

`endif

// ---- core/fda_pkg.sv ----
package fda_pkg;
  typedef logic [7:0] fda_duty_t;
  typedef logic [2:0] fda_ramp_code_t;
endpackage : fda_pkg

// ---- core/fda_ramp.sv ----
`timescale 1ns/1ps
`include "fda_defines.svh"
// Slew limiter for drive one duty
module fda_ramp
  import fda_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           reset_n,
  input  wire logic           ramp_enable,
  input  wire fda_ramp_code_t ramp_code,
  input  wire logic           slot_tick,
  input  wire fda_duty_t      target,
  output fda_duty_t           duty_r
);
  // Step lookup
  function automatic fda_duty_t fda_step(input fda_ramp_code_t c);
    unique case (c)
      3'h0: fda_step = `FDA_STEP_0;
      3'h1: fda_step = `FDA_STEP_1;
      3'h2: fda_step = `FDA_STEP_2;
      3'h3: fda_step = `FDA_STEP_3;
      3'h4: fda_step = `FDA_STEP_4;
      3'h5: fda_step = `FDA_STEP_5;
      3'h6: fda_step = `FDA_STEP_6;
      3'h7: fda_step = `FDA_STEP_7;
    endcase
  endfunction : fda_step

  fda_duty_t step;
  fda_duty_t duty_nxt;

  // Next duty toward target
  always_comb begin
    step = fda_step(ramp_code);
    duty_nxt = duty_r;
    if (!ramp_enable) begin
      duty_nxt = target;
    end else if (slot_tick) begin
      if (target > duty_r) begin
        duty_nxt = ((target - duty_r) > step) ? 8'(duty_r + step) : target;
      end else if (target < duty_r) begin
        duty_nxt = ((duty_r - target) > step) ? 8'(duty_r - step) : target;
      end
    end
  end

  // Duty register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) duty_r <= 8'h00;
    else duty_r <= duty_nxt;
  end

  property p_no_overshoot;
    @(posedge core_clk) disable iff (!reset_n)
      (ramp_enable && slot_tick && target > duty_r) |=> (duty_r <= $past(target));
  endproperty
  a_no_overshoot: assert property (p_no_overshoot) else $error("ramp overshoot up");

  property p_no_undershoot;
    @(posedge core_clk) disable iff (!reset_n)
      (ramp_enable && slot_tick && target < duty_r) |=> (duty_r >= $past(target));
  endproperty
  a_no_undershoot: assert property (p_no_undershoot) else $error("ramp overshoot down");

  property p_step_bound;
    @(posedge core_clk) disable iff (!reset_n)
      (ramp_enable && slot_tick && target > duty_r && (target - duty_r) > step)
        |=> (duty_r == $past(duty_r) + $past(step));
  endproperty
  a_step_bound: assert property (p_step_bound) else $error("ramp step wrong");

  property p_direct;
    @(posedge core_clk) disable iff (!reset_n)
      !ramp_enable |=> (duty_r == $past(target));
  endproperty
  a_direct: assert property (p_direct) else $error("direct duty not taken");

  property p_hold;
    @(posedge core_clk) disable iff (!reset_n)
      (ramp_enable && !slot_tick) |=> $stable(duty_r);
  endproperty
  a_hold: assert property (p_hold) else $error("duty moved off slot");

  c_ramp_up: cover property (@(posedge core_clk) ramp_enable && slot_tick && target > duty_r);
  c_ramp_dn: cover property (@(posedge core_clk) ramp_enable && slot_tick && target < duty_r);
endmodule : fda_ramp

// ---- tb/fda_host_model.sv ----
`timescale 1ns/1ps
// Host side of the register port
module fda_host_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] reg_rdata_r,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata
);
  // Idle port at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h5A;
  end
  // One-cycle strobe; released data shows its inverse
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wr    <= 1'b1;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask : write
  // Index held, data one cycle later
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    repeat (2) @(posedge core_clk);
    #1 d = reg_rdata_r;
  endtask : read
endmodule : fda_host_model

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
  import fda_pkg::*;
  logic       core_clk, reset_n, config_lock, auto_mode, slot_tick, reg_wr;
  logic [2:0] below_start;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_r, rd;
  logic       sync2, sync3, sync4;
  fda_duty_t  tgt [3];
  fda_duty_t  mins [3];
  fda_duty_t  drv [3];
  int         reg_m, duty_m, errors, checked;
  int         steps [8] = '{1, 2, 3, 4, 8, 12, 24, 48};
  fda_host_model i_host (.core_clk(core_clk), .reg_rdata_r(reg_rdata_r),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata));
  fda_config i_dut (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
    .config_lock(config_lock), .auto_mode(auto_mode), .slot_tick(slot_tick),
    .drive_one_target(tgt[0]), .drive_two_target(tgt[1]), .drive_three_target(tgt[2]),
    .drive_one_min(mins[0]), .drive_two_min(mins[1]), .drive_three_min(mins[2]),
    .below_start(below_start), .fan_drive_one_r(drv[0]), .fan_drive_two_r(drv[1]),
    .fan_drive_three_r(drv[2]), .speed_input_two_sync_r(sync2),
    .speed_input_three_sync_r(sync3), .speed_input_four_sync_r(sync4));
  // 25 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Duty each output should settle on before ramping
  function automatic int eff(int i);
    if (auto_mode && below_start[i]) return reg_m[5+i] ? int'(mins[i]) : 0;
    return int'(tgt[i]);
  endfunction : eff
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic check_rd(input logic [7:0] got, input logic [7:0] exp);
    check(got, exp);
  endtask : check_rd
  task automatic check_sync(input logic [7:0] got, input logic [7:0] exp);
    check(got, exp);
  endtask : check_sync
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle
  // Write through the host, track the register
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.write(a, d);
    if (a == 8'h62 && config_lock !== 1'b1) reg_m = d;
  endtask : wr
  task automatic check_drives();
    if (!reg_m[3]) duty_m = eff(0);
    check(drv[0], duty_m[7:0]);
    check(drv[1], 8'(eff(1)));
    check(drv[2], 8'(eff(2)));
  endtask : check_drives
  // One slot pulse, model steps toward target without overshoot
  task automatic tick();
    int s, t;
    @(posedge core_clk) slot_tick <= 1'b1;
    @(posedge core_clk) slot_tick <= 1'b0;
    s = steps[reg_m[2:0]];
    t = eff(0);
    if (duty_m < t) duty_m = (duty_m + s > t) ? t : duty_m + s;
    else duty_m = (duty_m - s < t) ? t : duty_m - s;
    settle(3);
  endtask : tick
  task automatic conclude();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  // Watchdog
  initial begin
    #400000;
    errors++;
    conclude();
  end
  // Main sequence
  initial begin
    {reset_n, config_lock, auto_mode, slot_tick, below_start} = '0;
    tgt = '{default: 8'h00};
    mins = '{default: 8'h00};
    {reg_m, duty_m, errors, checked} = '0;
    void'($urandom(32'h2104));
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    i_host.read(8'h62, rd);
    check_rd(rd, 8'h00);
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      wr(8'h62, 8'h08 | 8'(c));
      tgt[0] <= c[0] ? 8'($urandom_range(0, 40)) : 8'($urandom_range(200, 255));
      settle(2);
      check_drives();
      repeat (5) begin
        tick();
        check_drives();
      end
    end
    $display("test ramp done");
    wr(8'h62, 8'h00);
    for (int k = 0; k < 12; k++) begin
      if (k > 3) wr(8'h62, 8'($urandom_range(0, 7) << 5));
      else @(posedge core_clk);
      for (int i = 0; i < 3; i++) begin
        tgt[i] <= 8'($urandom);
        mins[i] <= 8'($urandom);
      end
      auto_mode <= k > 3 ? 1'($urandom) : 1'b0;
      below_start <= 3'($urandom);
      settle(3);
      check_drives();
    end
    $display("test floor done");
    for (int a = 0; a < 2; a++) begin
      wr(8'h62, 8'(a << 4));
      settle(3);
      check_sync({7'h00, sync2}, 8'(a));
      check_sync({6'h00, sync3, sync4}, 8'h03);
    end
    $display("test align done");
    @(posedge core_clk) config_lock <= 1'b1;
    settle(1);
    wr(8'h62, 8'hE5);
    i_host.read(8'h62, rd);
    check_rd(rd, reg_m[7:0]);
    @(posedge core_clk) config_lock <= 1'b0;
    wr(8'h63, 8'hFF);
    i_host.read(8'h63, rd);
    check_rd(rd, 8'h00);
    i_host.read(8'h62, rd);
    check_rd(rd, reg_m[7:0]);
    $display("test lock done");
    conclude();
  end
endmodule : tb
